// >>> gpc_pin1.sv
// first general-purpose pin: configuration word, pin drive, input functions, irq
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"
// How it works
// - bit15 input/output, bit9 push-pull or open drain
// - bits14:13 none, pull-down, pull-up; resets pull-down
// - bit12 rising edge or both edges irq
// - bit10 inverted when 0, default non-inverted
// - bit11 selects supply domain, default buffer
// - bit8 zero tri-states the pin
// - function 0 long debounce, 1 plain input
// - codes 2,5,6 on/off, sleep, power-on requests
// - codes 3,4 sleep/wake, 4 long debounced
// - code 7 pin services the watchdog
// - codes 8-9 voltage select, 10-11 hardware enables
// - code 12 first hardware control input
// - code 13 second hardware control input, 14-15 first and second long debounced
// - output code 0 level, 1 32kHz clock
module gpc_pin1 import gpc_pkg::*; #(
	parameter int LONG_DBNC_CYCLES = `GPC_LONG_DBNC_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// apb slave
	input wire logic [`GPC_ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// configuration loader
	input wire logic otp_load,
	input wire logic [`GPC_CFG_W-1:0] otp_word,
	// pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic pull_up_en,
	output logic pull_dn_en,
	output logic io_supply_domain,
	// clock source for output function
	input wire logic clk32k_in,
	// input function requests
	output logic pwr_onoff_req,
	output logic sleep_wake_req,
	output logic sleep_req,
	output logic pwr_on_req,
	output logic wdog_reset,
	output logic voltage_scale_sel_a,
	output logic voltage_scale_sel_b,
	output logic hw_enable_1,
	output logic hw_enable_2,
	output logic hw_control_1,
	output logic hw_control_2,
	// interrupt
	output logic irq
);

	gpc_cfg_t cfg;           // configuration word
	logic sts;               // sticky edge event
	logic mask;              // irq enable for the edge event
	logic data_out;          // general output level
	logic in_q;              // registered pin level
	logic act_q;             // active level after polarity
	logic act_prev;          // previous active level
	logic edge_evt;          // qualified edge this cycle
	logic in_mode;           // pin enabled as input
	logic long_sel;          // long filter chosen
	logic lvl;               // level before polarity
	logic act;               // level after polarity
	logic drv_lvl;           // output source level
	logic pin_lvl;           // output level after polarity
	logic next_oe;
	logic next_out;
	logic wr;                // write access phase
	logic rd_setup;          // read setup phase
	logic mapped;            // address hits a register
	logic [31:0] next_rdata;
	logic [15:0] idx;        // word index
	gpc_cfg_t wcfg;          // written value as a config word

	gpc_dbnc_if dbi ();

	// true when the word index selects the given register
	function automatic logic reg_hit(input logic [15:0] a, input logic [15:0] r,
			input logic [1:0] lo);
		reg_hit = (a == r) && (lo == `GPC_ALIGN_BITS);
	endfunction

	// functions filtered by the long debounce
	function automatic logic is_long(input logic [3:0] f);
		is_long = (f == GPC_FN_GPIO_LONG) || (f == GPC_FN_SLEEP_WAKE_LONG) ||
			(f == GPC_FN_HW_CTL1_LONG) || (f == GPC_FN_HW_CTL2_LONG);
	endfunction

	// active request for one input function code
	function automatic logic fn_hit(input gpc_cfg_t c, input logic a, input gpc_fn_t f);
		fn_hit = c.dir && c.ena && (c.fn == f) && a;
	endfunction

	// bus decode
	assign idx = paddr[`GPC_ADDR_W-1:2];
	assign wr = psel && penable && pwrite;
	assign rd_setup = psel && !penable && !pwrite;
	assign mapped = reg_hit(idx, `GPC_IDX_CFG, paddr[1:0]) ||
		reg_hit(idx, `GPC_IDX_STS, paddr[1:0]) ||
		reg_hit(idx, `GPC_IDX_MASK, paddr[1:0]) ||
		reg_hit(idx, `GPC_IDX_DATA, paddr[1:0]);
	assign pready = psel && penable;
	assign pslverr = psel && penable && !mapped;
	assign wcfg = gpc_cfg_t'(pwdata[`GPC_CFG_W-1:0] & `GPC_CFG_WMASK);

	// configuration word: loader wins over software
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cfg <= gpc_cfg_t'(`GPC_CFG_RESET);
		end else if (otp_load) begin
			cfg <= gpc_cfg_t'(otp_word & `GPC_CFG_WMASK);
		end else if (wr && reg_hit(idx, `GPC_IDX_CFG, paddr[1:0])) begin
			cfg <= wcfg;
		end
	end

	// mask and general output level
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mask <= 1'b0;
			data_out <= 1'b0;
		end else if (wr) begin
			if (reg_hit(idx, `GPC_IDX_MASK, paddr[1:0])) begin
				mask <= pwdata[`GPC_STS_EDGE_BIT];
			end
			if (reg_hit(idx, `GPC_IDX_DATA, paddr[1:0])) begin
				data_out <= pwdata[`GPC_DATA_OUT_BIT];
			end
		end
	end

	// sticky status, a new edge beats a write-one clear
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			sts <= 1'b0;
		end else if (edge_evt) begin
			sts <= 1'b1;
		end else if (wr && reg_hit(idx, `GPC_IDX_STS, paddr[1:0]) &&
				pwdata[`GPC_STS_EDGE_BIT]) begin
			sts <= 1'b0;
		end
	end

	assign irq = sts && mask;

	// read mux, captured in the setup phase
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (reg_hit(idx, `GPC_IDX_CFG, paddr[1:0])) begin
			next_rdata[`GPC_CFG_W-1:0] = cfg;
		end else if (reg_hit(idx, `GPC_IDX_STS, paddr[1:0])) begin
			next_rdata[`GPC_STS_EDGE_BIT] = sts;
		end else if (reg_hit(idx, `GPC_IDX_MASK, paddr[1:0])) begin
			next_rdata[`GPC_STS_EDGE_BIT] = mask;
		end else if (reg_hit(idx, `GPC_IDX_DATA, paddr[1:0])) begin
			next_rdata[`GPC_DATA_OUT_BIT] = data_out;
			next_rdata[`GPC_DATA_IN_BIT] = act_q;
		end
	end

	// read data register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata <= next_rdata;
		end
	end

	// input path and long filter
	assign dbi.raw = in_q;
	assign in_mode = cfg.dir && cfg.ena;
	assign long_sel = is_long(cfg.fn);
	assign lvl = long_sel ? dbi.level : in_q;
	assign act = lvl ~^ cfg.pol;

	gpc_dbnc #(
		.LIMIT(LONG_DBNC_CYCLES)
	) u_dbnc (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.dbi(dbi)
	);

	// sample pin and active level
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			in_q <= 1'b0;
			act_q <= 1'b0;
			act_prev <= 1'b0;
		end else begin
			in_q <= pin_in;
			act_q <= act;
			act_prev <= act_q;
		end
	end

	// edge on the polarity-corrected level
	assign edge_evt = in_mode && ((act_q && !act_prev) ||
		(cfg.irq_mode && !act_q && act_prev));

	// input function requests
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pwr_onoff_req <= 1'b0;
			sleep_wake_req <= 1'b0;
			sleep_req <= 1'b0;
			pwr_on_req <= 1'b0;
			wdog_reset <= 1'b0;
			voltage_scale_sel_a <= 1'b0;
			voltage_scale_sel_b <= 1'b0;
			hw_enable_1 <= 1'b0;
			hw_enable_2 <= 1'b0;
			hw_control_1 <= 1'b0;
			hw_control_2 <= 1'b0;
		end else begin
			pwr_onoff_req <= fn_hit(cfg, act_q, GPC_FN_ONOFF);
			sleep_req <= fn_hit(cfg, act_q, GPC_FN_SLEEP);
			pwr_on_req <= fn_hit(cfg, act_q, GPC_FN_PWR_ON);
			sleep_wake_req <= fn_hit(cfg, act_q, GPC_FN_SLEEP_WAKE) ||
				fn_hit(cfg, act_q, GPC_FN_SLEEP_WAKE_LONG);
			wdog_reset <= fn_hit(cfg, act_q, GPC_FN_WDOG);
			voltage_scale_sel_a <= fn_hit(cfg, act_q, GPC_FN_VSEL_A);
			voltage_scale_sel_b <= fn_hit(cfg, act_q, GPC_FN_VSEL_B);
			hw_enable_1 <= fn_hit(cfg, act_q, GPC_FN_HW_EN1);
			hw_enable_2 <= fn_hit(cfg, act_q, GPC_FN_HW_EN2);
			hw_control_1 <= fn_hit(cfg, act_q, GPC_FN_HW_CTL1) ||
				fn_hit(cfg, act_q, GPC_FN_HW_CTL1_LONG);
			hw_control_2 <= fn_hit(cfg, act_q, GPC_FN_HW_CTL2) ||
				fn_hit(cfg, act_q, GPC_FN_HW_CTL2_LONG);
		end
	end

	// output source, reserved output codes give level 0 before polarity
	always_comb begin
		case (cfg.fn)
			GPC_OUT_GPIO: drv_lvl = data_out;
			GPC_OUT_CLK32K: drv_lvl = clk32k_in;
			default: drv_lvl = 1'b0;
		endcase
		pin_lvl = drv_lvl ~^ cfg.pol;
		// open drain only pulls low, push-pull drives whenever enabled as output
		next_oe = cfg.ena && !cfg.dir && (!cfg.od || !pin_lvl);
		next_out = cfg.od ? 1'b0 : pin_lvl;
	end

	// registered pin drive and pad controls
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pin_out <= 1'b0;
			pin_oe <= 1'b0;
			pull_up_en <= 1'b0;
			pull_dn_en <= 1'b0;
			io_supply_domain <= 1'b0;
		end else begin
			pin_out <= next_out;
			pin_oe <= next_oe;
			pull_up_en <= (cfg.pull == `GPC_PULL_UP);
			pull_dn_en <= (cfg.pull == `GPC_PULL_DOWN);
			io_supply_domain <= cfg.domain;
		end
	end

	// checks on the block's outputs and internal state
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	property p_input_hiz;
		cfg.dir |=> !pin_oe;
	endproperty
	a_input_hiz: assert property (p_input_hiz) else $error("input pin is driven");

	property p_od_low_only;
		pin_oe && $past(cfg.od) |-> !pin_out;
	endproperty
	a_od_low_only: assert property (p_od_low_only) else $error("open drain drove high");

	property p_pull;
		(cfg.pull == `GPC_PULL_DOWN) |=> pull_dn_en && !pull_up_en;
	endproperty
	a_pull: assert property (p_pull) else $error("pull-down not applied");

	property p_rise_irq;
		in_mode && !cfg.irq_mode && act_q && !act_prev |=> sts;
	endproperty
	a_rise_irq: assert property (p_rise_irq) else $error("rising edge not flagged");

	property p_single_no_fall;
		in_mode && !cfg.irq_mode && !act_q && act_prev |-> !edge_evt;
	endproperty
	a_single_no_fall: assert property (p_single_no_fall) else $error("fall flagged");

	property p_pol;
		!is_long(cfg.fn) && $stable(cfg) |=> act_q == ($past(in_q) ~^ $past(cfg.pol));
	endproperty
	a_pol: assert property (p_pol) else $error("polarity not applied");

	property p_domain;
		1'b1 |=> io_supply_domain == $past(cfg.domain);
	endproperty
	a_domain: assert property (p_domain) else $error("supply domain wrong");

	property p_disabled_hiz;
		!cfg.ena |=> !pin_oe;
	endproperty
	a_disabled_hiz: assert property (p_disabled_hiz) else $error("disabled pin driven");

	property p_onoff;
		fn_hit(cfg, act_q, GPC_FN_ONOFF) |=> pwr_onoff_req && !sleep_req;
	endproperty
	a_onoff: assert property (p_onoff) else $error("on/off request missing");

	property p_wdog;
		fn_hit(cfg, act_q, GPC_FN_WDOG) |=> wdog_reset;
	endproperty
	a_wdog: assert property (p_wdog) else $error("watchdog input missing");

	property p_clk_out;
		!cfg.dir && cfg.ena && !cfg.od && cfg.pol && (cfg.fn == GPC_OUT_CLK32K)
			&& $stable(cfg) |=> pin_out == $past(clk32k_in);
	endproperty
	a_clk_out: assert property (p_clk_out) else $error("clock not driven");

	property p_fall_inverted;
		in_mode && !cfg.pol && !cfg.irq_mode && !long_sel && $fell(in_q) |-> ##2 sts;
	endproperty
	a_fall_inverted: assert property (p_fall_inverted) else $error("inverted fall lost");

	c_irq: cover property (irq);
	c_both_edges: cover property (in_mode && cfg.irq_mode && !act_q && act_prev);
	c_wdog: cover property (wdog_reset);
	c_clk_out: cover property (pin_oe && (cfg.fn == GPC_OUT_CLK32K));

endmodule // gpc_pin1
`default_nettype wire

// >>> gpc_params.svh
// constants for the first-pin configuration block
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH

// apb address width in bits
`define GPC_ADDR_W 18
// register indices, byte address is four times the index
`define GPC_IDX_CFG 16'h781A
`define GPC_IDX_STS 16'h7830
`define GPC_IDX_MASK 16'h7831
`define GPC_IDX_DATA 16'h7832
// low address bits of an aligned word
`define GPC_ALIGN_BITS 2'h0

// configuration word reset value and writable bits
`define GPC_CFG_RESET 16'hA400
`define GPC_CFG_WMASK 16'hFFF0
`define GPC_CFG_W 16

// pull field codes
`define GPC_PULL_NONE 2'h0
`define GPC_PULL_DOWN 2'h1
`define GPC_PULL_UP 2'h2

// bit positions in the data and status registers
`define GPC_DATA_OUT_BIT 0
`define GPC_DATA_IN_BIT 1
`define GPC_STS_EDGE_BIT 0

// long debounce length in clock cycles
`define GPC_LONG_DBNC_CYCLES 1000

`endif

// >>> gpc_pkg.sv
// types shared by the first-pin configuration block
`default_nettype none
package gpc_pkg;

	// configuration word layout, msb first
	typedef struct packed {
		logic dir;          // 1 input, 0 output
		logic [1:0] pull;   // pull resistor select
		logic irq_mode;     // 0 rising, 1 both edges
		logic domain;       // io supply domain
		logic pol;          // 1 non-inverted
		logic od;           // 1 open drain
		logic ena;          // 1 normal operation
		logic [3:0] fn;     // pin function
		logic [3:0] rsvd;   // not held here
	} gpc_cfg_t;

	// input function codes
	typedef enum logic [3:0] {
		GPC_FN_GPIO_LONG = 4'h0,
		GPC_FN_GPIO = 4'h1,
		GPC_FN_ONOFF = 4'h2,
		GPC_FN_SLEEP_WAKE = 4'h3,
		GPC_FN_SLEEP_WAKE_LONG = 4'h4,
		GPC_FN_SLEEP = 4'h5,
		GPC_FN_PWR_ON = 4'h6,
		GPC_FN_WDOG = 4'h7,
		GPC_FN_VSEL_A = 4'h8,
		GPC_FN_VSEL_B = 4'h9,
		GPC_FN_HW_EN1 = 4'hA,
		GPC_FN_HW_EN2 = 4'hB,
		GPC_FN_HW_CTL1 = 4'hC,
		GPC_FN_HW_CTL2 = 4'hD,
		GPC_FN_HW_CTL1_LONG = 4'hE,
		GPC_FN_HW_CTL2_LONG = 4'hF
	} gpc_fn_t;

	// output function codes handled here
	typedef enum logic [3:0] {
		GPC_OUT_GPIO = 4'h0,
		GPC_OUT_CLK32K = 4'h1
	} gpc_out_fn_t;

endpackage
`default_nettype wire

// >>> gpc_dbnc_if.sv
// carrier between the pin block and its debounce filter
`timescale 1ns/1ps
`default_nettype none
interface gpc_dbnc_if;
	logic raw;    // sampled pin level
	logic level;  // filtered level
	modport filt (input raw, output level);
	modport user (output raw, input level);
endinterface
`default_nettype wire

// >>> gpc_dbnc.sv
// long debounce filter counting stable clock cycles
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"
module gpc_dbnc import gpc_pkg::*; #(
	parameter int LIMIT = `GPC_LONG_DBNC_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// filter carrier
	gpc_dbnc_if.filt dbi
);
	localparam int CNT_W = $clog2(LIMIT + 1);

	logic [CNT_W-1:0] cnt; // cycles the raw level has differed

	// accept a change only after LIMIT differing cycles
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cnt <= '0;
			dbi.level <= 1'b0;
		end else if (dbi.raw == dbi.level) begin
			cnt <= '0;
		end else if (cnt == CNT_W'(LIMIT - 1)) begin
			cnt <= '0;
			dbi.level <= dbi.raw;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end

	property p_dbnc_wait;
		@(posedge clk_sys) disable iff (!resetn)
		$changed(dbi.level) |-> $past(cnt) == CNT_W'(LIMIT - 1);
	endproperty
	a_dbnc_wait: assert property (p_dbnc_wait) else $error("debounce level changed early");

endmodule // gpc_dbnc
`default_nettype wire

// >>> gpc_ext_pin.sv
// far-side logic on the pin: drives it, pulls it, or leaves it floating
`timescale 1ns/1ps
`default_nettype none
module gpc_ext_pin (
	// clock
	input wire logic clk_sys,
	// pad controls from the device
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic pull_up_en,
	input wire logic pull_dn_en,
	// far driver, set by the bench
	input wire logic ext_en,
	input wire logic ext_lvl,
	// resolved wire level
	output logic pin_in
);
	logic last; // previous wire level
	// device drive first, then far driver, then pulls
	always_comb begin
		if (pin_oe) pin_in = pin_out;
		else if (ext_en) pin_in = ext_lvl;
		else if (pull_up_en) pin_in = 1'b1;
		else if (pull_dn_en) pin_in = 1'b0;
		else pin_in = ~last; // floating wire drifts
	end
	// remember level so a float never holds it
	always_ff @(posedge clk_sys) last <= pin_in;
endmodule // gpc_ext_pin
`default_nettype wire

// >>> gpc_pin1_tb.sv
// self-checking bench for the first-pin configuration block
`timescale 1ns/1ps
`default_nettype none
`include "gpc_params.svh"
module gpc_pin1_tb;
	localparam int DB = 4; // shortened long debounce
	localparam logic [17:0] A_CFG = 18'(`GPC_IDX_CFG * 4);
	localparam logic [17:0] A_STS = 18'(`GPC_IDX_STS * 4);
	localparam logic [17:0] A_MSK = 18'(`GPC_IDX_MASK * 4);
	localparam logic [17:0] A_DAT = 18'(`GPC_IDX_DATA * 4);
	// function code to request bit, -1 for none
	localparam int IDX [16] = '{-1, -1, 10, 9, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0, 1, 0};
	logic clk_sys, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic otp_load, pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en;
	logic [15:0] otp_word;
	logic io_supply_domain, clk32k_in, irq, ext_en, ext_lvl;
	wire logic [10:0] req; // request outputs, on/off request at top
	int failures, num_checks;

	gpc_pin1 #(.LONG_DBNC_CYCLES(DB)) dut_u (.clk_sys(clk_sys), .resetn(resetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.otp_load(otp_load), .otp_word(otp_word), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pull_up_en(pull_up_en),
		.pull_dn_en(pull_dn_en), .io_supply_domain(io_supply_domain),
		.clk32k_in(clk32k_in), .pwr_onoff_req(req[10]), .sleep_wake_req(req[9]),
		.sleep_req(req[8]), .pwr_on_req(req[7]), .wdog_reset(req[6]),
		.voltage_scale_sel_a(req[5]), .voltage_scale_sel_b(req[4]),
		.hw_enable_1(req[3]), .hw_enable_2(req[2]), .hw_control_1(req[1]),
		.hw_control_2(req[0]), .irq(irq));

	gpc_ext_pin ext_u (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
		.pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .ext_en(ext_en),
		.ext_lvl(ext_lvl), .pin_in(pin_in));

	// free-running system clock
	always #2 clk_sys = ~clk_sys;

	// value compare
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one apb transfer, waits on pready, the watchdog ends a hang
	task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// let edges pass, then sample settled outputs
	task automatic wt(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// far driver level
	task automatic pin(input logic v);
		@(posedge clk_sys);
		ext_lvl <= v;
	endtask

	// reset values and an unmapped access
	task automatic t_reset;
		apb(0, A_CFG, 0);
		chk("cfg reset", 32'h0000A400, rd);
		chk("mapped err", 0, err);
		chk("pull down", 1, pull_dn_en);
		chk("oe idle", 0, pin_oe);
		chk("domain", 0, io_supply_domain);
		apb(0, 18'h00100, 0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, rd);
	endtask
	// field writes, reserved pull code, loader word
	task automatic t_cfg;
		apb(1, A_CFG, 32'h0000FFFF);
		apb(0, A_CFG, 0);
		chk("cfg low bits", 32'h0000FFF0, rd);
		chk("pull 11 up", 0, pull_up_en);
		chk("pull 11 down", 0, pull_dn_en);
		apb(1, A_CFG, 32'h00004800);
		wt(2);
		chk("pull up", 1, pull_up_en);
		chk("domain aon", 1, io_supply_domain);
		@(posedge clk_sys);
		otp_load <= 1'b1;
		otp_word <= 16'h8C5F;
		@(posedge clk_sys);
		otp_load <= 1'b0;
		apb(0, A_CFG, 0);
		chk("otp load", 32'h00008C50, rd);
	endtask
	// output drive: level, polarity, open drain, clock source
	task automatic t_out;
		@(posedge clk_sys);
		ext_en <= 1'b0;
		apb(1, A_CFG, 32'h00002500);
		apb(1, A_DAT, 1);
		wt(2);
		chk("out level", 1, pin_out);
		chk("out oe", 1, pin_oe);
		apb(1, A_CFG, 32'h00002100);
		wt(2);
		chk("out inverted", 0, pin_out);
		apb(1, A_CFG, 32'h00002700);
		wt(2);
		chk("od high oe", 0, pin_oe);
		apb(1, A_DAT, 0);
		wt(2);
		chk("od low oe", 1, pin_oe);
		chk("od low out", 0, pin_out);
		apb(1, A_CFG, 32'h00002510);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_sys);
			clk32k_in <= ~i[0];
			wt(3);
			chk("clk out", !i[0], pin_out);
		end
		apb(1, A_CFG, 32'h00008500);
		pin(0);
		ext_en <= 1'b1;
	endtask
	// every input function code raises only its request
	task automatic t_fn;
		for (int f = 0; f < 16; f++) begin
			pin(0);
			apb(1, A_CFG, 32'h00008500 | (f << 4));
			wt(12);
			pin(1);
			wt(12);
			chk("requests", (IDX[f] < 0) ? 0 : (1 << IDX[f]), req);
		end
		apb(0, A_DAT, 0);
		chk("input level", 2, rd & 2);
		apb(1, A_CFG, 32'h00008420);
		wt(2);
		chk("disabled req", 0, req);
	endtask
	// pulse one cycle short of the filter, then a long one
	task automatic t_dbnc;
		apb(1, A_CFG, 32'h00008500);
		pin(0);
		wt(12);
		repeat (DB - 1) pin(1);
		pin(0);
		wt(12);
		apb(0, A_DAT, 0);
		chk("short pulse", 0, rd & 2);
		pin(1);
		wt(12);
		apb(0, A_DAT, 0);
		chk("long pulse", 2, rd & 2);
	endtask
	// edge modes, mask, clear, inverted polarity
	task automatic t_irq;
		apb(1, A_CFG, 32'h00008510);
		pin(0);
		apb(1, A_MSK, 1);
		apb(1, A_STS, 1);
		pin(1);
		wt(4);
		chk("irq rise", 1, irq);
		apb(1, A_STS, 1);
		wt(1);
		chk("irq cleared", 0, irq);
		pin(0);
		wt(4);
		apb(0, A_STS, 0);
		chk("fall mode0", 0, rd);
		apb(1, A_CFG, 32'h00009510);
		pin(1);
		wt(4);
		apb(1, A_STS, 1);
		pin(0);
		wt(4);
		apb(1, A_MSK, 0);
		wt(1);
		chk("masked irq", 0, irq);
		apb(0, A_STS, 0);
		chk("fall mode1", 1, rd);
		apb(1, A_CFG, 32'h00008110);
		wt(4);
		apb(1, A_STS, 1);
		pin(1);
		wt(4);
		apb(0, A_STS, 0);
		chk("inv rise", 0, rd);
		pin(0);
		wt(4);
		apb(0, A_STS, 0);
		chk("inv fall", 1, rd);
	endtask

	// counts, verdict, end of run
	task automatic report_and_stop;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		clk_sys = 0;
		resetn = 0;
		{psel, penable, pwrite, otp_load, clk32k_in, ext_lvl} = '0;
		paddr = '0;
		pwdata = '0;
		otp_word = '0;
		ext_en = 1;
		failures = 0;
		num_checks = 0;
		repeat (8) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset;
		t_cfg;
		t_out;
		t_fn;
		t_dbnc;
		t_irq;
		report_and_stop;
	end
	// hang guard, far beyond the expected run
	initial begin
		#100000;
		failures++;
		report_and_stop;
	end
endmodule // gpc_pin1_tb
`default_nettype wire
